// ---- verilog/uwpp_pkg.sv ----
// Package of constants for the serial transceiver with parallel port
// Summary of operation
// - Baud rates 110, 300, 600 and 1200 are chosen by host command.
// - Transmit and receive are double buffered; receiver checks start, framing, overrun.
// - One 8-bit port works as latched output or as input sampled on read.
// - Setup_command byte: upper three bits zero, bits 4..1 select rate, bit 0 direction.
// - Port-transfer command is 0x80, error-clear is 0xC0, decoded apart from setup_command.
// - Port-transfer: output direction takes next data byte; input direction samples port.
// - Error-clear command clears both receiver error bits in status.
// - Status bit 0 sets whenever a byte is loaded into the read buffer.
// - Status bits 2 and 3 tell whether the read byte is serial or parallel.
// - Status bit 6 sets when a received character has an invalid stop bit.
// - Status bit 7 sets when a new character overwrites an unread one.
// - Error bits stay until error-clear and never stop the receiver.
// - Serial output is high for mark and low for space.
// - Transmit interrupt pin has exactly the timing of status bit 5.
// - Read-buffer-full flag is copied to the data-available interrupt pin.
// - Diagnostic pin pulses once per baud tick, four times the baud rate.
// - Setup_command loads a divider constant; each tick services receiver and transmitter.
// - After a good start the receiver samples every fourth tick, keeping four flags.
// - Assembled character waits in holding register until the read buffer is free.
// - Writing a transmit byte clears status bit 5 and its interrupt pin.
// - Good start presets shift register to 80H; marker shifting out ends assembly.
// - Setup_command selecting input direction drives all port bits to ones.
package uwpp_pkg;
  // Bus word offsets (byte addresses)
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_CMD = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // Status byte bit positions
  localparam int ST_OUT_FULL = 0;
  localparam int ST_IN_FULL = 1;
  localparam int ST_SRC_LO = 2;
  localparam int ST_SRC_HI = 3;
  localparam int ST_TX_EMPTY = 5;
  localparam int ST_FRAME = 6;
  localparam int ST_OVERRUN = 7;
  // Source codes in status bits 3:2
  localparam logic [1:0] SRC_SERIAL = 2'h1;
  localparam logic [1:0] SRC_PARALLEL = 2'h2;
  // Command encodings
  localparam logic [7:0] CMD_PORT_XFER = 8'h80;
  localparam logic [7:0] CMD_ERR_CLEAR = 8'hC0;
  localparam int CFG_DIR = 0;
  localparam int CFG_110 = 1;
  localparam int CFG_300 = 2;
  localparam int CFG_600 = 3;
  localparam int CFG_1200 = 4;
  // Reference rate and divider constants, rounded to nearest count
  localparam int REF_HZ = 76800;
  localparam int TICKS_PER_BIT = 4;
  localparam logic [7:0] DIV_1200 = 8'((REF_HZ + 2 * 1200) / (TICKS_PER_BIT * 1200));
  localparam logic [7:0] DIV_600 = 8'((REF_HZ + 2 * 600) / (TICKS_PER_BIT * 600));
  localparam logic [7:0] DIV_300 = 8'((REF_HZ + 2 * 300) / (TICKS_PER_BIT * 300));
  localparam logic [7:0] DIV_110 = 8'((REF_HZ + 2 * 110) / (TICKS_PER_BIT * 110));
  // Receiver and transmitter timing in ticks
  localparam logic [2:0] RX_MID_TICKS = 3'h2;
  localparam logic [2:0] RX_BIT_TICKS = 3'h4;
  localparam logic [1:0] TX_BIT_TICKS_M1 = 2'h3;
  localparam logic [7:0] RX_PRESET = 8'h80;
  localparam logic [3:0] TX_DATA_BITS = 4'h8;
  // Reset values
  localparam logic [7:0] PORT_RST = 8'hFF;
endpackage

// ---- verilog/uwpp_baud_if.sv ----
// Interface between the control logic and the baud tick divider
interface uwpp_baud_if;
  logic ref_edge;
  logic run;
  logic load;
  logic [7:0] divisor;
  logic tick;
  modport ctl (output ref_edge, output run, output load, output divisor, input tick);
  modport gen (input ref_edge, input run, input load, input divisor, output tick);
endinterface

// ---- verilog/uwpp_baud_gen.sv ----
// Baud tick divider counting reference edges
module uwpp_baud_gen (
  input wire logic clock,
  input wire logic rst,
  uwpp_baud_if.gen bif
);
  import uwpp_pkg::*;

  typedef struct packed {
    logic [7:0] div;
    logic [7:0] cnt;
    logic tick;
  } uwpp_gen_st_t;

  uwpp_gen_st_t s_q;
  uwpp_gen_st_t s_d;

  // One tick after every divisor reference edges
  // divider reload and count
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (bif.load) begin
      s_d.div = bif.divisor;
      s_d.cnt = 8'h00;
    end else if (bif.run && bif.ref_edge) begin
      if (s_q.cnt >= s_q.div - 8'h01) begin
        s_d.cnt = 8'h00;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bif.tick = s_q.tick;
endmodule

// ---- verilog/uwpp_top.sv ----
// Serial transceiver with programmable parallel port behind a Wishbone slave
module uwpp_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ref_clock_pin,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic tx_irq_pin,
  output logic data_avail_irq_pin,
  output logic tick_sample_pin,
  input wire logic [7:0] port_in,
  output logic [7:0] port_out,
  output logic [7:0] port_oe
);
  import uwpp_pkg::*;

  typedef struct packed {
    // Pin synchronisers
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic rx_s1;
    logic rx_s2;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    // Bus answer
    logic ack;
    logic [31:0] rdata;
    // Host buffers and status
    logic in_buf_full;
    logic wr_is_cmd;
    logic [7:0] host_write_buffer;
    logic out_buf_full;
    logic [7:0] host_read_buffer;
    logic [1:0] src;
    logic tx_empty_flag;
    logic frame_err;
    logic overrun_err;
    // Configuration and parallel port
    logic dir_out;
    logic io_req;
    logic run;
    logic load;
    logic [7:0] divisor;
    logic [7:0] port_q;
    // Receiver, rx_state_flags
    logic rx_active;
    logic good_start;
    logic byte_done;
    logic data_ready;
    logic [2:0] rx_tick;
    logic [7:0] rx_shift;
    logic [7:0] rx_hold;
    // Transmitter, tx_state_flags
    logic tx_busy;
    logic tx_req;
    logic [7:0] tx_hold;
    logic [7:0] tx_shift;
    logic [1:0] tx_tick;
    logic [3:0] tx_bits;
    logic tx_line;
    logic tick_pulse;
  } uwpp_st_t;

  uwpp_st_t s_q;
  uwpp_st_t s_d;
  uwpp_baud_if bif ();
  logic tick;
  logic bus_req;
  logic [7:0] status_byte;

  // Tick divider
  uwpp_baud_gen u_gen (
    .clock(clock),
    .rst(rst),
    .bif(bif)
  );

  // Divider control taken straight from state
  // reference edge after two synchroniser stages
  assign bif.ref_edge = s_q.ref_s2 & ~s_q.ref_s3;
  assign bif.run = s_q.run;
  assign bif.load = s_q.load;
  assign bif.divisor = s_q.divisor;
  assign tick = bif.tick;

  // New request seen on the bus, answered next cycle
  assign bus_req = wb_cyc_i & wb_stb_i & ~s_q.ack;

  // Status byte assembly, bit 4 unused
  // source code in bits 3:2
  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_OUT_FULL] = s_q.out_buf_full;
    status_byte[ST_IN_FULL] = s_q.in_buf_full;
    status_byte[ST_SRC_LO] = s_q.src[0];
    status_byte[ST_SRC_HI] = s_q.src[1];
    status_byte[ST_TX_EMPTY] = s_q.tx_empty_flag;
    status_byte[ST_FRAME] = s_q.frame_err;
    status_byte[ST_OVERRUN] = s_q.overrun_err;
  end

  // Whole next-state computation
  always_comb begin
    s_d = s_q;
    s_d.load = 1'b0;
    s_d.tick_pulse = 1'b0;

    // Pins pass two flops before any logic reads them
    s_d.ref_s1 = ref_clock_pin;
    s_d.ref_s2 = s_q.ref_s1;
    s_d.ref_s3 = s_q.ref_s2;
    s_d.rx_s1 = serial_in_pin;
    s_d.rx_s2 = s_q.rx_s1;
    s_d.pin_s1 = port_in;
    s_d.pin_s2 = s_q.pin_s1;

    // Bus slave: ack one cycle after the request, dropped the cycle after
    s_d.ack = bus_req;
    s_d.rdata = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      if (wb_adr_i == ADDR_DATA) begin
        s_d.rdata = {24'h00_0000, s_q.host_read_buffer};
        s_d.out_buf_full = 1'b0;
      end else if (wb_adr_i == ADDR_STATUS) begin
        s_d.rdata = {24'h00_0000, status_byte};
      end
    end

    // Consume a byte the host wrote one cycle earlier
    if (s_q.in_buf_full) begin
      s_d.in_buf_full = 1'b0;
      if (s_q.wr_is_cmd) begin
        if (s_q.host_write_buffer[7:5] == 3'h0) begin
          s_d.dir_out = s_q.host_write_buffer[CFG_DIR];
          s_d.io_req = 1'b0;
          s_d.run = 1'b1;
          s_d.load = 1'b1;
          if (s_q.host_write_buffer[CFG_1200]) begin
            s_d.divisor = DIV_1200;
          end else if (s_q.host_write_buffer[CFG_600]) begin
            s_d.divisor = DIV_600;
          end else if (s_q.host_write_buffer[CFG_300]) begin
            s_d.divisor = DIV_300;
          end else if (s_q.host_write_buffer[CFG_110]) begin
            s_d.divisor = DIV_110;
          end else begin
            s_d.run = 1'b0;
          end
          // input direction sets port to ones
          if (!s_q.host_write_buffer[CFG_DIR]) begin
            s_d.port_q = PORT_RST;
          end
        end else if (s_q.host_write_buffer == CMD_PORT_XFER) begin
          s_d.io_req = 1'b1;
        end else if (s_q.host_write_buffer == CMD_ERR_CLEAR) begin
          // error clear, a same-cycle set still wins below
          s_d.frame_err = 1'b0;
          s_d.overrun_err = 1'b0;
        end
      end else if (s_q.io_req && s_q.dir_out) begin
        // data byte after port transfer goes to the port
        s_d.port_q = s_q.host_write_buffer;
        s_d.io_req = 1'b0;
      end else begin
        // new transmit byte clears the empty flag
        s_d.tx_hold = s_q.host_write_buffer;
        s_d.tx_req = 1'b1;
        s_d.tx_empty_flag = 1'b0;
      end
    end

    // Host write; a write while busy is dropped, host must wait on bit 1
    // busy flag guards the write buffer
    if (bus_req && wb_we_i && wb_sel_i[0] && !s_q.in_buf_full) begin
      if (wb_adr_i == ADDR_DATA || wb_adr_i == ADDR_CMD) begin
        s_d.host_write_buffer = wb_dat_i[7:0];
        s_d.wr_is_cmd = (wb_adr_i == ADDR_CMD);
        s_d.in_buf_full = 1'b1;
      end
    end

    // Load read buffer when free; receiver has priority over port
    // holding register waits for a free buffer
    if (!s_q.out_buf_full) begin
      if (s_q.data_ready) begin
        s_d.host_read_buffer = s_q.rx_hold;
        s_d.src = SRC_SERIAL;
        s_d.out_buf_full = 1'b1;
        s_d.data_ready = 1'b0;
      end else if (s_q.io_req && !s_q.dir_out) begin
        // input direction samples the pins now
        s_d.host_read_buffer = s_q.pin_s2;
        s_d.src = SRC_PARALLEL;
        s_d.out_buf_full = 1'b1;
        s_d.io_req = 1'b0;
      end
    end

    // receiver and transmitter serviced on each tick
    if (tick) begin
      s_d.tick_pulse = 1'b1;

      // Receiver
      if (!s_q.rx_active) begin
        if (!s_q.rx_s2) begin
          s_d.rx_active = 1'b1;
          s_d.rx_tick = RX_MID_TICKS;
        end
      end else if (s_q.rx_tick != 3'h1) begin
        s_d.rx_tick = s_q.rx_tick - 3'h1;
      end else if (!s_q.good_start) begin
        if (!s_q.rx_s2) begin
          s_d.good_start = 1'b1;
          s_d.rx_tick = RX_BIT_TICKS;
          s_d.rx_shift = RX_PRESET;
        end else begin
          s_d.rx_active = 1'b0;
        end
      end else if (!s_q.byte_done) begin
        // one sample every fourth tick, LSB first
        s_d.rx_tick = RX_BIT_TICKS;
        s_d.rx_shift = {s_q.rx_s2, s_q.rx_shift[7:1]};
        s_d.byte_done = s_q.rx_shift[0];
      end else begin
        // Stop bit sample ends the character
        s_d.rx_active = 1'b0;
        s_d.good_start = 1'b0;
        s_d.byte_done = 1'b0;
        s_d.rx_hold = s_q.rx_shift;
        s_d.data_ready = 1'b1;
        if (!s_q.rx_s2) begin
          s_d.frame_err = 1'b1;
        end
        if (s_q.data_ready) begin
          s_d.overrun_err = 1'b1;
        end
      end

      // Transmitter, one bit time is four ticks
      if (!s_q.tx_busy) begin
        if (s_q.tx_req) begin
          s_d.tx_line = 1'b0;
          s_d.tx_shift = s_q.tx_hold;
          s_d.tx_req = 1'b0;
          s_d.tx_busy = 1'b1;
          s_d.tx_bits = 4'h0;
          s_d.tx_tick = TX_BIT_TICKS_M1;
          s_d.tx_empty_flag = 1'b1;
        end
      end else if (s_q.tx_tick != 2'h0) begin
        s_d.tx_tick = s_q.tx_tick - 2'h1;
      end else begin
        s_d.tx_tick = TX_BIT_TICKS_M1;
        if (s_q.tx_bits < TX_DATA_BITS) begin
          // data bit level straight onto the line
          s_d.tx_line = s_q.tx_shift[0];
          s_d.tx_shift = {1'b0, s_q.tx_shift[7:1]};
          s_d.tx_bits = s_q.tx_bits + 4'h1;
        end else if (s_q.tx_bits == TX_DATA_BITS) begin
          s_d.tx_line = 1'b1;
          s_d.tx_bits = s_q.tx_bits + 4'h1;
        end else begin
          s_d.tx_busy = 1'b0;
        end
      end
    end
  end

  // State register; constants only under reset
  // error bits change only by receiver set or clear command
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.ref_s1 <= 1'b1;
      s_q.ref_s2 <= 1'b1;
      s_q.ref_s3 <= 1'b1;
      s_q.rx_s1 <= 1'b1;
      s_q.rx_s2 <= 1'b1;
      s_q.tx_line <= 1'b1;
      s_q.tx_empty_flag <= 1'b1;
      s_q.port_q <= PORT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  // transmit interrupt is the empty flag itself
  // data-available pin is the buffer-full flag
  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign serial_out_pin = s_q.tx_line;
  assign tx_irq_pin = s_q.tx_empty_flag;
  assign data_avail_irq_pin = s_q.out_buf_full;
  assign tick_sample_pin = s_q.tick_pulse;
  assign port_out = s_q.port_q;
  assign port_oe = {8{s_q.dir_out}};
endmodule

// ---- sim/uwpp_props.sv ----
// Concurrent checks on the transceiver top-level ports
module uwpp_props
  import uwpp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic serial_out_pin,
  input wire logic tick_sample_pin,
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] since_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Cycles since the last tick, saturating so idle lines never wrap
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      since_q <= 3'h7;
    end else begin
      since_q <= tick_sample_pin ? 3'h0 : (since_q == 3'h7 ? 3'h7 : since_q + 3'h1);
    end
  end
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_status_layout: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ADDR_STATUS |-> wb_dat_o[31:8] == 24'h000000 && !wb_dat_o[4])
    else $error("status read has stray bits");
  a_tick_gap: assert property (tick_sample_pin |=> !tick_sample_pin [*8])
    else $error("ticks too close together");
  a_oe_whole: assert property (port_oe == 8'h00 || port_oe == 8'hFF)
    else $error("port direction split");
  a_input_ones: assert property (port_oe == 8'h00 |-> port_out == PORT_RST)
    else $error("input port not driven to ones");
  a_tx_on_tick: assert property ($changed(serial_out_pin) |-> tick_sample_pin || since_q <= 3'h3)
    else $error("serial output moved off a tick");
endmodule
bind uwpp_top uwpp_props u_props (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .serial_out_pin(serial_out_pin), .tick_sample_pin(tick_sample_pin), .port_out(port_out), .port_oe(port_oe));

// ---- sim/uwpp_host.sv ----
// Host processor model issuing classic Wishbone cycles
module uwpp_host
  import uwpp_pkg::*;
(
  input wire logic clock,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [3:0] sel,
  output logic [3:0] adr,
  output logic [31:0] dat_w,
  input wire logic [31:0] dat_r,
  input wire logic ack
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 4'h0;
    dat_w = 32'h0;
  end
  // One cycle, held unchanged until ack is seen
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    dat_w <= {24'h0, d};
    do @(posedge clock); while (ack !== 1'b1);
    q = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Busy bit polled first; a dropped write would hang the bench
  // busy bit honoured
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] s;
    do xfer(1'b0, ADDR_STATUS, 8'h00, s); while (s[1] !== 1'b0);
    xfer(1'b1, a, d, s);
  endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the serial transceiver with parallel port
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import uwpp_pkg::*;
  logic clock, rst, ref_clk, ser_in, cyc, stb, we, ack, ser_out, tx_irq, dav, tick, m_full, m_ovr, m_frm;
  logic [3:0] adr, sel;
  logic [31:0] dw, dr;
  logic [1:0] m_src;
  logic [7:0] pin, pout, poe, q, cap, txd[2];
  logic [7:0] rx_q[$];
  logic [31:0] seed = 32'hAFC5;
  int error_cnt = 0;
  int cmp_count = 0;
  int bauds[4] = '{110, 300, 600, 1200};
  real t_start, per, want;
  uwpp_top u_dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .ref_clock_pin(ref_clk),
    .serial_in_pin(ser_in), .serial_out_pin(ser_out), .tx_irq_pin(tx_irq), .data_avail_irq_pin(dav),
    .tick_sample_pin(tick), .port_in(pin), .port_out(pout), .port_oe(poe));
  uwpp_host u_host (.clock(clock), .cyc(cyc), .stb(stb), .we(we), .sel(sel), .adr(adr), .dat_w(dw), .dat_r(dr),
    .ack(ack));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Reference sped up to 110 ns so a frame fits the run; unrelated to the clock phase
  // free-running unsynchronised reference
  initial begin
    ref_clk = 1'b0;
    forever #55 ref_clk = ~ref_clk;
  end
  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Status byte predicted from the model flags
  function logic [7:0] stat_exp();
    return {m_ovr, m_frm, 1'b1, 1'b0, m_src, 1'b0, m_full};
  endfunction
  task automatic check8(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      do @(posedge clock); while (tick !== 1'b1);
    end
  endtask
  task automatic stat();
    u_host.xfer(1'b0, ADDR_STATUS, 8'h00, q);
  endtask
  task automatic wait_full();
    do stat(); while (q[0] !== 1'b1);
  endtask
  // Line changes on tick edges, so every sample lands three ticks into its four-tick bit
  task automatic send(input logic [7:0] d, input logic stop);
    ticks(1);
    ser_in <= 1'b0;
    ticks(4);
    for (int i = 0; i < 8; i++) begin
      ser_in <= d[i];
      ticks(4);
    end
    ser_in <= stop;
    ticks(4);
    ser_in <= 1'b1;
    ticks(4);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #1500000;
    error_cnt++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    ser_in = 1'b1;
    pin = 8'h00;
    {m_full, m_ovr, m_frm, m_src} = 5'h00;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    stat();
    check8(stat_exp(), q);
    check8(8'h0C, {4'h0, ser_out, tx_irq, dav, tick});
    check8(PORT_RST, pout);
    // Every rate in turn; 1200 output is left selected
    for (int i = 0; i < 4; i++) begin
      u_host.put(ADDR_CMD, (8'h02 << i) | 8'h01);
      ticks(2);
      t_start = $realtime;
      ticks(1);
      per = $realtime - t_start;
      want = ((76800 + 2 * bauds[i]) / (4 * bauds[i])) * 110.0;
      check8(8'h01, {7'h0, per > want - 60.0 && per < want + 60.0});
    end
    cap = rnd();
    u_host.put(ADDR_CMD, CMD_PORT_XFER);
    u_host.put(ADDR_DATA, cap);
    repeat (3) @(posedge clock);
    check8(cap, pout);
    check8(8'hFF, poe);
    txd[0] = rnd();
    txd[1] = rnd();
    fork
      for (int k = 0; k < 2; k++) begin
        do @(posedge clock); while (ser_out !== 1'b0);
        ticks(2);
        for (int i = 0; i < 8; i++) begin
          ticks(4);
          cap[i] = ser_out;
        end
        ticks(4);
        check8(8'h01, {7'h0, ser_out});
        check8(txd[k], cap);
      end
      begin
        u_host.put(ADDR_DATA, txd[0]);
        ticks(2);
        check8(8'h01, {7'h0, tx_irq});
        u_host.put(ADDR_DATA, txd[1]);
        ticks(1);
        check8(8'h00, {7'h0, tx_irq});
        stat();
        check8(8'h00, q & 8'h20);
      end
    join
    pin <= rnd();
    u_host.put(ADDR_CMD, 8'h10);
    repeat (3) @(posedge clock);
    check8(PORT_RST, pout);
    check8(8'h00, poe);
    u_host.put(ADDR_CMD, CMD_PORT_XFER);
    wait_full();
    {m_full, m_src} = {1'b1, SRC_PARALLEL};
    check8(stat_exp(), q);
    check8(8'h01, {7'h0, dav});
    u_host.xfer(1'b0, ADDR_DATA, 8'h00, q);
    check8(pin, q);
    m_full = 1'b0;
    // Short low pulse must be abandoned at mid-bit; dropped right after a tick so the next tick sees it
    ticks(1);
    ser_in <= 1'b0;
    ticks(1);
    repeat (4) @(posedge clock);
    ser_in <= 1'b1;
    // Long enough for a wrongly kept frame to reach the read buffer
    ticks(44);
    stat();
    check8(stat_exp(), q);
    // Three unread characters: the third overwrites the held one
    for (int k = 0; k < 3; k++) begin
      cap = rnd();
      send(cap, 1'b1);
      if (rx_q.size() == 2) begin
        void'(rx_q.pop_back());
        m_ovr = 1'b1;
      end
      rx_q.push_back(cap);
    end
    {m_full, m_src} = {1'b1, SRC_SERIAL};
    stat();
    check8(stat_exp(), q);
    for (int k = 0; k < 2; k++) begin
      wait_full();
      u_host.xfer(1'b0, ADDR_DATA, 8'h00, q);
      check8(rx_q.pop_front(), q);
    end
    cap = rnd();
    send(cap, 1'b0);
    m_frm = 1'b1;
    stat();
    check8(stat_exp() & 8'hC0, q & 8'hC0);
    // Errors are set, yet the character still arrives
    u_host.xfer(1'b0, ADDR_DATA, 8'h00, q);
    check8(cap, q);
    u_host.put(ADDR_CMD, CMD_ERR_CLEAR);
    stat();
    check8(8'h00, q & 8'hC0);
    u_host.xfer(1'b0, 4'hC, 8'h00, q);
    check8(8'h00, q);
    // Setup_command with no rate bit stops the ticks; one tick may still be in flight
    u_host.put(ADDR_CMD, 8'h00);
    repeat (4) @(posedge clock);
    cap = 8'h00;
    repeat (200) begin
      @(posedge clock);
      cap = cap | {7'h0, tick};
    end
    check8(8'h00, cap);
    finish_test();
  end
endmodule
